//--- rtl/bdp_consts.vh
// Constants for the byte-wide digital I/O port
`ifndef BDP_CONSTS_VH
`define BDP_CONSTS_VH
`define BDP_DIR_RESET 8'h00
`define BDP_DRIVE_PUSH_PULL 1'b0
`define BDP_DRIVE_OPEN_DRAIN 1'b1
`define BDP_DRIVE_RESET 1'b0
`define BDP_PORT_RESET 8'h00
`define BDP_PORT_VALID 8'h00
`define BDP_PULLUP_RESET 1'b0
`define BDP_LIMIT_MS_RESET 32'd30000
`define BDP_CLK_HZ 125000000
`define BDP_CYC_PER_MS (`BDP_CLK_HZ / 1000)
`define BDP_OP_NONE 2'd0
`define BDP_OP_PORT 2'd1
`define BDP_OP_LINE 2'd2
`endif

//--- rtl/bdp_timer.v
// Millisecond time limit watcher for port operations
`timescale 1ns/1ps
`default_nettype none
`include "bdp_consts.vh"
module bdp_timer #(
  parameter CYC_PER_MS = `BDP_CYC_PER_MS
)
(
  input wire clk, // System clock
  input wire rst_n, // Synchronous reset, active low
  input wire run, // Operation in progress
  input wire [31:0] limit_ms, // Time limit in milliseconds
  output wire expired // Limit reached while running
);
  reg [31:0] cyc_ff;
  reg [31:0] ms_ff;
  wire ms_tick;

  assign ms_tick = (cyc_ff == CYC_PER_MS - 1);
  // Count only while an operation runs; restart for each operation
  always @(posedge clk)
  begin
    if (!rst_n || !run)
    begin
      cyc_ff <= 32'h0;
      ms_ff <= 32'h0;
    end
    else
    begin
      cyc_ff <= ms_tick ? 32'h0 : cyc_ff + 32'h1;
      if (ms_tick && !expired)
        ms_ff <= ms_ff + 32'h1;
    end
  end
  // At least the full limit elapses before expiry
  assign expired = run && (ms_ff >= limit_ms);
endmodule // bdp_timer
`default_nettype wire

//--- rtl/bdp_port.v
// Byte-wide digital I/O port with direction, drive style and time limit
// What this block does
// - A direction bit of 1 makes its line an output and 0 makes it an input.
// - The direction bitmap resets to zero so every line starts as an input.
// - The drive style of the active port selects open-drain or push-pull outputs.
// - The drive style resets to push-pull.
// - The active-port selector resets to 0 and only 0 is valid on this single-port block.
// - A single-line read gives 0 for a low line level and 1 for a high one.
// - One global time limit bounds each operation before it is called timed out.
// - The time limit resets to 30000 milliseconds.
// - The pull-up enable connects the two-wire bus pull-ups when set.
// - A port-wide write changes only lines marked as outputs.
// - A port-wide read gives bit n for line n, input level or driven level.
// - A single-line write to an output line of 1 drives high in push-pull or releases it in open-drain, and of 0 drives low.
`timescale 1ns/1ps
`default_nettype none
`include "bdp_consts.vh"
module bdp_port #(
  parameter WIDTH = 8,
  parameter CYC_PER_MS = `BDP_CYC_PER_MS
)
(
  input wire clk, // System clock
  input wire rst_n, // Synchronous reset, active low
  input wire cfg_we, // Configuration write strobe
  input wire [7:0] cfg_port, // Active port select value
  input wire cfg_drive, // Drive style, 1 open-drain
  input wire [WIDTH-1:0] cfg_dir, // Direction bitmap value
  input wire cfg_pullup, // Pull-up enable value
  input wire limit_we, // Time limit write strobe
  input wire [31:0] limit_ms, // Time limit value in ms
  input wire op_start, // Start one operation, pulse
  input wire op_write, // 1 write, 0 read
  input wire op_line, // 1 single line, 0 whole port
  input wire [7:0] op_port, // Port number of operation
  input wire [2:0] op_lnum, // Line number for line ops
  input wire [WIDTH-1:0] op_data, // Write value
  input wire op_hold, // Stretch operation, for limit tests
  output reg op_busy_ff, // Operation in progress
  output reg op_done_ff, // Operation finished, pulse
  output reg op_err_ff, // Bad port number, sticky to next op
  output reg op_timeout_ff, // Timed out, sticky to next op
  output reg [WIDTH-1:0] rd_data_ff, // Read result
  output reg [7:0] active_port_select_ff, // Active port
  output reg output_drive_style_ff, // Drive style
  output reg [WIDTH-1:0] line_direction_bitmap_ff, // Direction map
  output reg [31:0] operation_time_limit_ff, // Time limit ms
  output reg pullup_en_ff, // Two-wire bus pull-ups connected
  input wire [WIDTH-1:0] dio_in, // Pin levels
  output wire [WIDTH-1:0] dio_out, // Pin output levels
  output wire [WIDTH-1:0] dio_oe_n // Pin drive enable, low drives
);
  // Pin levels after the two-stage synchroniser
  reg [WIDTH-1:0] sync1_ff;
  reg [WIDTH-1:0] sync2_ff;

  // Driven output value and the operation captured at start
  reg [WIDTH-1:0] out_ff;
  reg wr_ff;
  reg line_ff;
  reg [2:0] lnum_ff;
  reg [WIDTH-1:0] data_ff;

  // Merged write value, read-back level and time limit state
  reg [WIDTH-1:0] nxt_out;
  wire [WIDTH-1:0] level;
  wire expired;
  genvar g;

  // Only port 0 exists; any other number is refused
  function port_valid;
    input [7:0] port_num;
    begin
      port_valid = (port_num == `BDP_PORT_VALID);
    end
  endfunction

  // Two-stage synchroniser on the pins
  // Inputs read back two cycles after the pin changes
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1_ff <= {WIDTH{1'b0}};
      sync2_ff <= {WIDTH{1'b0}};
    end
    else
    begin
      sync1_ff <= dio_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Outputs report their own driven value, inputs the pin
  // Open-drain outputs still read back the driven value, not the pin
  assign level = (line_direction_bitmap_ff & out_ff) | (~line_direction_bitmap_ff & sync2_ff);

  // Pin drivers: open-drain releases high, push-pull drives both levels
  // An open-drain high needs a pull-up outside; without one the pin floats
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_pin
      assign dio_out[g] = out_ff[g];
      assign dio_oe_n[g] = ~(line_direction_bitmap_ff[g] &
        (output_drive_style_ff == `BDP_DRIVE_PUSH_PULL || !out_ff[g]));
    end
  endgenerate

  // Configuration; a bad port number is refused
  // Refusal is silent; the host sees no error for a bad configuration port
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      active_port_select_ff <= `BDP_PORT_RESET;
      output_drive_style_ff <= `BDP_DRIVE_RESET;
      line_direction_bitmap_ff <= `BDP_DIR_RESET;
      pullup_en_ff <= `BDP_PULLUP_RESET;
      operation_time_limit_ff <= `BDP_LIMIT_MS_RESET;
    end
    else
    begin
      if (cfg_we && port_valid(cfg_port))
      begin
        active_port_select_ff <= cfg_port;
        output_drive_style_ff <= cfg_drive;
        line_direction_bitmap_ff <= cfg_dir;
        pullup_en_ff <= cfg_pullup;
      end
      // A new limit applies at once, also to a running operation
      if (limit_we)
        operation_time_limit_ff <= limit_ms;
    end
  end

  // Write value merged under the direction mask
  always @*
  begin
    nxt_out = out_ff;
    if (line_ff)
    begin
      // A line write to an input line is dropped
      if (line_direction_bitmap_ff[lnum_ff])
        nxt_out[lnum_ff] = data_ff[0];
    end
    else
      nxt_out = (out_ff & ~line_direction_bitmap_ff) | (data_ff & line_direction_bitmap_ff);
  end

  // Operation sequencer: capture, complete next cycle unless held
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_ff <= {WIDTH{1'b0}};
      wr_ff <= 1'b0;
      line_ff <= 1'b0;
      lnum_ff <= 3'h0;
      data_ff <= {WIDTH{1'b0}};
      op_busy_ff <= 1'b0;
      op_done_ff <= 1'b0;
      op_err_ff <= 1'b0;
      op_timeout_ff <= 1'b0;
      rd_data_ff <= {WIDTH{1'b0}};
    end
    else
    begin
      // Done is a one-cycle pulse
      op_done_ff <= 1'b0;
      if (!op_busy_ff && op_start)
      begin
        op_err_ff <= 1'b0;
        op_timeout_ff <= 1'b0;
        // A refused port finishes at once with the error flag
        if (!port_valid(op_port))
        begin
          op_err_ff <= 1'b1;
          op_done_ff <= 1'b1;
        end
        else
        begin
          op_busy_ff <= 1'b1;
          wr_ff <= op_write;
          line_ff <= op_line;
          lnum_ff <= op_lnum;
          data_ff <= op_data;
        end
      end
      // Timeout wins over completion, so a held write is dropped
      else if (op_busy_ff && expired)
      begin
        op_busy_ff <= 1'b0;
        op_timeout_ff <= 1'b1;
        op_done_ff <= 1'b1;
      end
      // Normal completion: a write merges, a read captures
      else if (op_busy_ff && !op_hold)
      begin
        op_busy_ff <= 1'b0;
        op_done_ff <= 1'b1;
        if (wr_ff)
          out_ff <= nxt_out;
        else if (line_ff)
          rd_data_ff <= {{(WIDTH-1){1'b0}}, level[lnum_ff]};
        else
          rd_data_ff <= level;
      end
    end
  end

  // Time limit watcher
  // Its counters restart whenever the sequencer is idle
  bdp_timer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .run(op_busy_ff),
    .limit_ms(operation_time_limit_ff),
    .expired(expired)
  );
endmodule // bdp_port
`default_nettype wire

//--- tb/bdp_port_monitor.sv
// Checker for the digital I/O port
`timescale 1ns/1ps
`default_nettype none
module bdp_mon (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic cfg_we, // Cfg load
  input wire logic [7:0] cfg_port, // Cfg port
  input wire logic op_start, // Start
  input wire logic op_busy_ff, // Busy
  input wire logic op_done_ff, // Done
  input wire logic op_err_ff, // Error
  input wire logic [7:0] op_port, // Op port
  input wire logic [7:0] line_direction_bitmap_ff, // Dir
  input wire logic output_drive_style_ff, // Style
  input wire logic [7:0] dio_out, // Out
  input wire logic [7:0] dio_oe_n // Enables
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Reset values, enables, refusals and op timing
  property p_dir; $rose(rst_n) |-> line_direction_bitmap_ff == 8'h00; endproperty
  a_dir: assert property (p_dir) else $error("dir reset");
  property p_drv; $rose(rst_n) |-> !output_drive_style_ff; endproperty
  a_drv: assert property (p_drv) else $error("style reset");
  property p_pp; !output_drive_style_ff |-> dio_oe_n == ~line_direction_bitmap_ff; endproperty
  a_pp: assert property (p_pp) else $error("push-pull enables");
  property p_od; output_drive_style_ff |-> dio_oe_n == ~(line_direction_bitmap_ff & ~dio_out); endproperty
  a_od: assert property (p_od) else $error("open-drain enables");
  property p_bad; cfg_we && cfg_port != 8'h00 |=> $stable(line_direction_bitmap_ff); endproperty
  a_bad: assert property (p_bad) else $error("cfg refused");
  property p_err; op_start && !op_busy_ff && op_port != 8'h00 |=> op_done_ff && op_err_ff; endproperty
  a_err: assert property (p_err) else $error("port error");
  property p_run; op_start && !op_busy_ff && op_port == 8'h00 |=> op_busy_ff && !op_done_ff; endproperty
  a_run: assert property (p_run) else $error("busy");
  property p_pls; op_done_ff |=> !op_done_ff; endproperty
  a_pls: assert property (p_pls) else $error("done pulse");
  c_od: cover property (output_drive_style_ff && line_direction_bitmap_ff != 8'h00);
  c_err: cover property (op_err_ff && op_done_ff);
  c_run: cover property (op_start ##2 op_done_ff);
endmodule // bdp_mon
bind bdp_port bdp_mon i_mon (.clk(clk), .rst_n(rst_n), .cfg_we(cfg_we), .cfg_port(cfg_port), .op_start(op_start),
  .op_busy_ff(op_busy_ff), .op_done_ff(op_done_ff), .op_err_ff(op_err_ff), .op_port(op_port),
  .line_direction_bitmap_ff(line_direction_bitmap_ff), .output_drive_style_ff(output_drive_style_ff),
  .dio_out(dio_out), .dio_oe_n(dio_oe_n));
`default_nettype wire

//--- tb/bdp_pins.sv
// Outside circuitry on the port pins
`timescale 1ns/1ps
`default_nettype none
module bdp_pins (
  input wire logic [7:0] dio_out, // Device levels
  input wire logic [7:0] dio_oe_n, // Low drives
  input wire logic [7:0] ext, // Outside levels
  output logic [7:0] dio_in // Pin levels
);
  // Released lines show what the outside drives
  assign dio_in = (~dio_oe_n & dio_out) | (dio_oe_n & ext);
endmodule // bdp_pins
`default_nettype wire

//--- tb/tb_bdp_port.sv
// Self-checking bench for the digital I/O port
`timescale 1ns/1ps
`default_nettype none
module tb_bdp_port;
  logic clk = '0, rst_n = '0, cfg_we = '0, cfg_drive = '0, cfg_pullup = '0, limit_we = '0, op_start = '0;
  logic op_write = '0, op_line = '0, op_hold = '0, op_busy_ff, op_done_ff, op_err_ff, op_timeout_ff;
  logic output_drive_style_ff, pullup_en_ff;
  logic [2:0] op_lnum = '0;
  logic [31:0] limit_ms = '0, operation_time_limit_ff;
  logic [7:0] cfg_port = '0, cfg_dir = '0, op_port = '0, op_data = '0, ext = 8'ha5, rd_data_ff, dio_in, dio_out;
  logic [7:0] active_port_select_ff, line_direction_bitmap_ff, dio_oe_n;
  int fails = 0, n_tests = 0, cyc = 0;
  // Short millisecond so the time limit test takes a few cycles
  bdp_port #(.WIDTH(8), .CYC_PER_MS(4)) i_dut (
    .clk(clk), .rst_n(rst_n), .cfg_we(cfg_we), .cfg_port(cfg_port), .cfg_drive(cfg_drive), .cfg_dir(cfg_dir),
    .cfg_pullup(cfg_pullup), .limit_we(limit_we), .limit_ms(limit_ms), .op_start(op_start), .op_write(op_write),
    .op_line(op_line), .op_port(op_port), .op_lnum(op_lnum), .op_data(op_data), .op_hold(op_hold),
    .op_busy_ff(op_busy_ff), .op_done_ff(op_done_ff), .op_err_ff(op_err_ff), .op_timeout_ff(op_timeout_ff),
    .rd_data_ff(rd_data_ff), .active_port_select_ff(active_port_select_ff),
    .output_drive_style_ff(output_drive_style_ff), .line_direction_bitmap_ff(line_direction_bitmap_ff),
    .operation_time_limit_ff(operation_time_limit_ff), .pullup_en_ff(pullup_en_ff),
    .dio_in(dio_in), .dio_out(dio_out), .dio_oe_n(dio_oe_n)
  );
  bdp_pins i_pins (.dio_out(dio_out), .dio_oe_n(dio_oe_n), .ext(ext), .dio_in(dio_in));
  always #4 clk = ~clk; // 8 ns period
  // Hang guard; the whole run needs well under 300 cycles
  always @(posedge clk) if (++cyc == 3000) end_of_test;
  task automatic end_of_test;
    fails += (cyc >= 3000);
    $display("fails %0d of %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    fails += (g !== e);
    if (g !== e) $display("[FAIL] %s exp %h got %h", nm, e, g);
  endtask
  // Strobes rise and drop on rising edges; results are read at the falling edge, when settled
  task automatic cfg(logic [7:0] p, logic d, logic [7:0] m, logic u);
    @(posedge clk) {cfg_we, cfg_port, cfg_drive, cfg_dir, cfg_pullup} <= {1'h1, p, d, m, u};
    @(posedge clk) cfg_we <= 1'h0;
    @(negedge clk);
  endtask
  task automatic op(logic w, logic l, logic [7:0] p, logic [2:0] n, logic [7:0] d);
    @(posedge clk) {op_start, op_write, op_line, op_port, op_lnum, op_data} <= {1'h1, w, l, p, n, d};
    @(posedge clk) op_start <= 1'h0;
    @(negedge clk);
    for (int k = 0; k < 40 && op_done_ff !== 1'h1; k++)
      @(negedge clk);
  endtask
  // Push-pull port and line writes, reads of inputs and outputs
  task automatic t_io;
    cfg(8'h00, 1'h0, 8'h0f, 1'h0);
    chk("oe pp", 8'hf0, dio_oe_n);
    op(1'h1, 1'h0, 8'h00, 3'h0, 8'hff);
    chk("out", 8'h0f, dio_out);
    op(1'h1, 1'h1, 8'h00, 3'h2, 8'h00);
    op(1'h1, 1'h1, 8'h00, 3'h5, 8'h01);
    chk("line wr", 8'h0b, dio_out);
    op(1'h0, 1'h0, 8'h00, 3'h0, 8'h00);
    chk("port rd", 8'hab, rd_data_ff);
    op(1'h0, 1'h1, 8'h00, 3'h7, 8'h00);
    chk("line rd", 8'h01, rd_data_ff);
    op(1'h0, 1'h1, 8'h00, 3'h2, 8'h00);
    chk("line rd out", 8'h00, rd_data_ff);
  endtask
  // Open-drain enables, pull-ups and refused port numbers
  task automatic t_drv;
    cfg(8'h00, 1'h1, 8'h0f, 1'h1);
    chk("pullup", 1'h1, pullup_en_ff);
    chk("oe od", 8'hfb, dio_oe_n);
    op(1'h1, 1'h1, 8'h00, 3'h2, 8'h01);
    chk("line hi", 8'h0f, dio_out);
    chk("oe od hi", 8'hff, dio_oe_n);
    cfg(8'h01, 1'h0, 8'hff, 1'h0);
    chk("dir kept", 8'h0f, line_direction_bitmap_ff);
    chk("style kept", 1'h1, output_drive_style_ff);
    op(1'h0, 1'h0, 8'h01, 3'h0, 8'h00);
    chk("port err", 1'h1, op_err_ff);
  endtask
  // Time limit: reset value, write, and a held operation timing out
  task automatic t_lim;
    chk("limit", 32'h7530, operation_time_limit_ff);
    chk("port", 8'h00, active_port_select_ff);
    @(posedge clk) {limit_we, limit_ms, op_hold} <= {1'h1, 32'h1, 1'h1};
    @(posedge clk) limit_we <= 1'h0;
    @(negedge clk);
    chk("limit set", 32'h1, operation_time_limit_ff);
    op(1'h0, 1'h0, 8'h00, 3'h0, 8'h00);
    chk("timeout", 1'h1, op_timeout_ff);
    chk("err clear", 1'h0, op_err_ff);
    @(posedge clk) op_hold <= 1'h0;
  endtask
  // Reset in mid-run brings every setting back to its reset value
  task automatic t_rst;
    @(posedge clk) rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    chk("dir rst", 8'h00, line_direction_bitmap_ff);
    chk("oe rst", 8'hff, dio_oe_n);
    chk("style rst", 1'h0, output_drive_style_ff);
    chk("limit rst", 32'h7530, operation_time_limit_ff);
    chk("pullup rst", 1'h0, pullup_en_ff);
    chk("tmo rst", 1'h0, op_timeout_ff);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    t_io;
    t_drv;
    t_lim;
    t_rst;
    end_of_test;
  end
endmodule // tb_bdp_port
`default_nettype wire
